// ===== acc_cfg_pkg.sv
// constants, codes and carrier types of the fifo and secondary link setup
package acc_cfg_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_FRAME_OPTIONS   = 8'h48;
    localparam logic [7:0] OFS_SOURCE_SELECT   = 8'h49;
    localparam logic [7:0] OFS_SLAVE_ADDRESS   = 8'h4B;
    localparam logic [7:0] OFS_LINK_SETUP      = 8'h4C;
    localparam logic [7:0] OFS_FETCH_POINTER   = 8'h4D;
    localparam logic [7:0] OFS_STORE_POINTER   = 8'h4E;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_FRAME_OPTIONS   = 8'h02;
    localparam logic [7:0] RST_SOURCE_SELECT   = 8'h10;
    localparam logic [7:0] RST_SLAVE_ADDRESS   = 8'h20;
    localparam logic [7:0] RST_LINK_SETUP      = 8'h83;
    localparam logic [7:0] RST_FETCH_POINTER   = 8'h42;
    localparam logic [7:0] RST_STORE_POINTER   = 8'h4C;

    // ****************************************
    // writable bits of each register
    // ****************************************
    localparam logic [7:0] MSK_FRAME_OPTIONS   = 8'h03;
    localparam logic [7:0] MSK_SOURCE_SELECT   = 8'h7C;
    localparam logic [7:0] MSK_SLAVE_ADDRESS   = 8'hFE;
    localparam logic [7:0] MSK_LINK_SETUP      = 8'h83;
    localparam logic [7:0] MSK_FULL_BYTE       = 8'hFF;

    // ****************************************
    // field positions
    // ****************************************
    localparam int POS_STOP_ON_FULL = 0;
    localparam int POS_TIME_EN      = 1;
    localparam int POS_IRQ_TWO      = 2;
    localparam int POS_IRQ_ONE      = 3;
    localparam int POS_HEADER_EN    = 4;
    localparam int POS_AUX_EN       = 5;
    localparam int POS_ACC_EN       = 6;
    localparam int POS_MANUAL       = 7;
    localparam int POS_ADDR_LSB     = 1;
    localparam int POS_BURST_LSB    = 0;

    // ****************************************
    // read burst codes and byte counts
    // ****************************************
    localparam logic [1:0] LENGTH_ONE_BYTE     = 2'h0;
    localparam logic [1:0] LENGTH_TWO_BYTES    = 2'h1;
    localparam logic [1:0] LENGTH_SIX_BYTES    = 2'h2;
    localparam logic [1:0] LENGTH_EIGHT_BYTES  = 2'h3;
    localparam logic [3:0] BYTES_ONE           = 4'h1;
    localparam logic [3:0] BYTES_TWO           = 4'h2;
    localparam logic [3:0] BYTES_SIX           = 4'h6;
    localparam logic [3:0] BYTES_EIGHT         = 4'h8;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic       stop_on_full;
        logic       time_en;
        logic       acc_en;
        logic       aux_en;
        logic       header_en;
        logic       irq_one_marking;
        logic       irq_two_marking;
        logic [6:0] slave_addr;
        logic       manual;
        logic [1:0] burst;
        logic [7:0] fetch_ptr;
        logic [7:0] store_ptr;
    } cfg_t;

    typedef struct packed {
        logic acc;
        logic aux;
        logic header;
        logic tag_one;
        logic tag_two;
    } frame_t;

    localparam cfg_t CFG_RST = '{
        stop_on_full:    1'b0,
        time_en:         1'b1,
        acc_en:          1'b0,
        aux_en:          1'b0,
        header_en:       1'b1,
        irq_one_marking: 1'b0,
        irq_two_marking: 1'b0,
        slave_addr:      7'h10,
        manual:          1'b1,
        burst:           2'h3,
        fetch_ptr:       8'h42,
        store_ptr:       8'h4C
    };

endpackage : acc_cfg_pkg

// ===== fifo_frame_and_aux_if_config.sv
// fifo frame setup and secondary link setup registers with link-side use
//
// Notes on behaviour
// - full-stop bit set: no writes while full
// - time enable: time frame after last read
// - header enable stores header; else equal rates
// - aux enable stores all three aux axes
// - acc enable stores all three accel axes
// - first interrupt tag follows its enable bit
// - second interrupt tag follows its enable bit
// - slave address bits 7..1, reset 0x20
// - burst code selects 1, 2, 6, 8 bytes
// - manual bit: 1 setup, 0 data, reset 1
// - read pointer register, eight bits, reset 0x42
// - write pointer register, eight bits, reset 0x4C
module fifo_frame_and_aux_if_config (
    input  wire logic                 REF_CLK,
    input  wire logic                 SRST,
    input  wire logic                 REG_WE,
    input  wire logic                 REG_RE,
    input  wire logic [7:0]           REG_ADDR,
    input  wire logic [7:0]           REG_WDATA,
    output logic      [7:0]           REG_RDATA,
    output logic                      REG_RVALID,
    output logic                      CFG_BUSY,
    input  wire logic                 LINK_CLK,
    input  wire logic                 ACC_SAMPLE,
    input  wire logic                 AUX_SAMPLE,
    input  wire logic                 FIFO_FULL,
    input  wire logic                 IRQ_ONE,
    input  wire logic                 IRQ_TWO,
    input  wire logic                 FIFO_LAST_READ,
    output logic                      FIFO_WRITE,
    output acc_cfg_pkg::frame_t       FRAME,
    output logic                      TIME_FRAME,
    output logic      [6:0]           SLAVE_ADDR,
    output logic                      MANUAL_MODE,
    output logic      [3:0]           BURST_BYTES,
    output logic      [7:0]           FETCH_PTR,
    output logic      [7:0]           STORE_PTR
);
    import acc_cfg_pkg::*;

    // ****************************************
    // host side registers
    // ****************************************
    logic [7:0] options_q;
    logic [7:0] sources_q;
    logic [7:0] slave_q;
    logic [7:0] setup_q;
    logic [7:0] fetch_q;
    logic [7:0] store_q;
    cfg_t       cfg_d;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            options_q <= RST_FRAME_OPTIONS;
            sources_q <= RST_SOURCE_SELECT;
            slave_q   <= RST_SLAVE_ADDRESS;
            setup_q   <= RST_LINK_SETUP;
            fetch_q   <= RST_FETCH_POINTER;
            store_q   <= RST_STORE_POINTER;
        end else if (REG_WE) begin
            // masks keep reserved bits at zero
            unique case (REG_ADDR)
                OFS_FRAME_OPTIONS: options_q <= REG_WDATA & MSK_FRAME_OPTIONS;
                OFS_SOURCE_SELECT: sources_q <= REG_WDATA & MSK_SOURCE_SELECT;
                OFS_SLAVE_ADDRESS: slave_q   <= REG_WDATA & MSK_SLAVE_ADDRESS;
                OFS_LINK_SETUP:    setup_q   <= REG_WDATA & MSK_LINK_SETUP;
                OFS_FETCH_POINTER: fetch_q   <= REG_WDATA & MSK_FULL_BYTE;
                OFS_STORE_POINTER: store_q   <= REG_WDATA & MSK_FULL_BYTE;
                default: ;
            endcase
        end
    end

    // ****************************************
    // read port, one cycle latency
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RE;
            if (REG_RE) begin
                unique case (REG_ADDR)
                    OFS_FRAME_OPTIONS: REG_RDATA <= options_q;
                    OFS_SOURCE_SELECT: REG_RDATA <= sources_q;
                    OFS_SLAVE_ADDRESS: REG_RDATA <= slave_q;
                    OFS_LINK_SETUP:    REG_RDATA <= setup_q;
                    OFS_FETCH_POINTER: REG_RDATA <= fetch_q;
                    OFS_STORE_POINTER: REG_RDATA <= store_q;
                    default:           REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    always_comb begin
        cfg_d.stop_on_full    = options_q[POS_STOP_ON_FULL];
        cfg_d.time_en         = options_q[POS_TIME_EN];
        cfg_d.acc_en          = sources_q[POS_ACC_EN];
        cfg_d.aux_en          = sources_q[POS_AUX_EN];
        cfg_d.header_en       = sources_q[POS_HEADER_EN];
        cfg_d.irq_one_marking = sources_q[POS_IRQ_ONE];
        cfg_d.irq_two_marking = sources_q[POS_IRQ_TWO];
        cfg_d.slave_addr      = slave_q[POS_ADDR_LSB +: 7];
        cfg_d.manual          = setup_q[POS_MANUAL];
        cfg_d.burst           = setup_q[POS_BURST_LSB +: 2];
        cfg_d.fetch_ptr       = fetch_q;
        cfg_d.store_ptr       = store_q;
    end

    // ****************************************
    // crossing: toggle handshake, held word
    // ****************************************
    // hold_q stays still while a transfer is in flight, so the link
    // side never samples a changing word
    cfg_t hold_q;
    logic req_tog_q;
    logic dirty_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_tog_q;
    logic busy;

    assign busy     = req_tog_q != ack_s2_q;
    assign CFG_BUSY = busy | dirty_q;

    always_ff @(posedge REF_CLK) begin
        ack_s1_q <= ack_tog_q;
        ack_s2_q <= ack_s1_q;
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            hold_q    <= CFG_RST;
            req_tog_q <= 1'b0;
            dirty_q   <= 1'b0;
        end else begin
            // a write in the launch cycle re-arms dirty: set beats clear
            if (REG_WE) begin
                dirty_q <= 1'b1;
            end else if (dirty_q && !busy) begin
                dirty_q <= 1'b0;
            end
            if (dirty_q && !busy) begin
                hold_q    <= cfg_d;
                req_tog_q <= ~req_tog_q;
            end
        end
    end

    // ****************************************
    // link domain reset and request capture
    // ****************************************
    // link reset needs a few link edges inside the host reset pulse
    logic rst_s1_q;
    logic link_rst;
    logic req_s1_q;
    logic req_s2_q;
    cfg_t lcfg_q;

    always_ff @(posedge LINK_CLK) begin
        rst_s1_q <= SRST;
        link_rst <= rst_s1_q;
        req_s1_q <= req_tog_q;
        req_s2_q <= req_s1_q;
    end

    always_ff @(posedge LINK_CLK) begin
        if (link_rst) begin
            lcfg_q    <= CFG_RST;
            ack_tog_q <= 1'b0;
        end else if (req_s2_q != ack_tog_q) begin
            lcfg_q    <= hold_q;
            ack_tog_q <= req_s2_q;
        end
    end

    // ****************************************
    // frame store gating
    // ****************************************
    logic store_acc;
    logic store_aux;
    logic room;

    assign store_acc = ACC_SAMPLE && lcfg_q.acc_en;
    assign store_aux = AUX_SAMPLE && lcfg_q.aux_en;
    assign room      = !(lcfg_q.stop_on_full && FIFO_FULL);

    always_ff @(posedge LINK_CLK) begin
        if (link_rst) begin
            FIFO_WRITE <= 1'b0;
            FRAME      <= '0;
            TIME_FRAME <= 1'b0;
        end else begin
            FIFO_WRITE     <= (store_acc || store_aux) && room;
            FRAME.acc      <= store_acc;
            FRAME.aux      <= store_aux;
            FRAME.header   <= lcfg_q.header_en;
            FRAME.tag_one  <= lcfg_q.irq_one_marking && IRQ_ONE;
            FRAME.tag_two  <= lcfg_q.irq_two_marking && IRQ_TWO;
            TIME_FRAME     <= FIFO_LAST_READ && lcfg_q.time_en;
        end
    end

    // ****************************************
    // secondary link settings
    // ****************************************
    always_ff @(posedge LINK_CLK) begin
        if (link_rst) begin
            SLAVE_ADDR  <= CFG_RST.slave_addr;
            MANUAL_MODE <= CFG_RST.manual;
            BURST_BYTES <= BYTES_EIGHT;
            FETCH_PTR   <= CFG_RST.fetch_ptr;
            STORE_PTR   <= CFG_RST.store_ptr;
        end else begin
            SLAVE_ADDR  <= lcfg_q.slave_addr;
            MANUAL_MODE <= lcfg_q.manual;
            FETCH_PTR   <= lcfg_q.fetch_ptr;
            STORE_PTR   <= lcfg_q.store_ptr;
            unique case (lcfg_q.burst)
                LENGTH_ONE_BYTE:    BURST_BYTES <= BYTES_ONE;
                LENGTH_TWO_BYTES:   BURST_BYTES <= BYTES_TWO;
                LENGTH_SIX_BYTES:   BURST_BYTES <= BYTES_SIX;
                LENGTH_EIGHT_BYTES: BURST_BYTES <= BYTES_EIGHT;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_stop_when_full: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        (lcfg_q.stop_on_full && FIFO_FULL) |=> !FIFO_WRITE)
        else $error("fifo written while full with stop enabled");

    chk_write_past_full: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        (!lcfg_q.stop_on_full && FIFO_FULL && (store_acc || store_aux))
        |=> FIFO_WRITE)
        else $error("fifo write dropped while stop disabled");

    chk_time_frame_gate: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        FIFO_LAST_READ |=> (TIME_FRAME == $past(lcfg_q.time_en)))
        else $error("time frame does not follow its enable");

    chk_header_follows: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        FIFO_WRITE |-> (FRAME.header == $past(lcfg_q.header_en)))
        else $error("frame header flag wrong");

    chk_aux_store: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        (AUX_SAMPLE && !lcfg_q.aux_en) |=> !FRAME.aux)
        else $error("aux data stored while disabled");

    chk_aux_written: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        (AUX_SAMPLE && lcfg_q.aux_en && room) |=> (FIFO_WRITE && FRAME.aux))
        else $error("aux sample not stored");

    chk_acc_store: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        (ACC_SAMPLE && lcfg_q.acc_en && room) |=> (FIFO_WRITE && FRAME.acc))
        else $error("accel sample not stored");

    chk_tag_one: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        FRAME.tag_one |-> $past(IRQ_ONE && lcfg_q.irq_one_marking))
        else $error("first interrupt tag without cause");

    chk_tag_one_off: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        !lcfg_q.irq_one_marking |=> !FRAME.tag_one)
        else $error("first interrupt tag while disabled");

    chk_tag_two: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        FRAME.tag_two |-> $past(IRQ_TWO && lcfg_q.irq_two_marking))
        else $error("second interrupt tag without cause");

    chk_tag_two_off: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        !lcfg_q.irq_two_marking |=> !FRAME.tag_two)
        else $error("second interrupt tag while disabled");

    chk_time_frame_only: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        TIME_FRAME |-> $past(FIFO_LAST_READ && lcfg_q.time_en))
        else $error("time frame without a last read");

    chk_link_reset_cfg: assert property (
        @(posedge LINK_CLK)
        link_rst |=> (SLAVE_ADDR == CFG_RST.slave_addr && MANUAL_MODE &&
                      BURST_BYTES == BYTES_EIGHT))
        else $error("link settings miss their reset values");

    chk_reset_values: assert property (
        @(posedge REF_CLK)
        SRST |=> (slave_q == RST_SLAVE_ADDRESS &&
                  setup_q == RST_LINK_SETUP &&
                  fetch_q == RST_FETCH_POINTER &&
                  store_q == RST_STORE_POINTER))
        else $error("register reset value wrong");

    chk_burst_decode: assert property (
        @(posedge LINK_CLK) disable iff (link_rst)
        ($past(lcfg_q.burst) == LENGTH_SIX_BYTES && !$past(link_rst))
        |-> (BURST_BYTES == 4'h6))
        else $error("burst length decode wrong");

    chk_manual_mode: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (REG_WE && REG_ADDR == OFS_LINK_SETUP)
        |=> (setup_q[POS_MANUAL] == $past(REG_WDATA[POS_MANUAL])))
        else $error("manual bit not written");

    chk_pointer_write: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (REG_WE && (REG_ADDR == OFS_FETCH_POINTER ||
                    REG_ADDR == OFS_STORE_POINTER))
        |=> (($past(REG_ADDR) == OFS_FETCH_POINTER ? fetch_q : store_q)
             == $past(REG_WDATA)))
        else $error("pointer register not written");

    chk_reserved_zero: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        REG_RVALID && $past(REG_ADDR) == OFS_SLAVE_ADDRESS
        |-> (REG_RDATA[0] == 1'b0))
        else $error("reserved bit reads non zero");

    chk_reserved_masked: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        ((options_q & ~MSK_FRAME_OPTIONS) == 8'h00) &&
        ((sources_q & ~MSK_SOURCE_SELECT) == 8'h00) &&
        ((slave_q & ~MSK_SLAVE_ADDRESS) == 8'h00) &&
        ((setup_q & ~MSK_LINK_SETUP) == 8'h00))
        else $error("reserved bit holds a one");

endmodule : fifo_frame_and_aux_if_config

// ===== link_side_model.sv
// far-side model: sample pulses, fifo full and interrupt levels
module link_side_model (
    input  wire logic link_clk,
    output logic      acc_sample,
    output logic      aux_sample,
    output logic      fifo_full,
    output logic      irq_one,
    output logic      irq_two,
    output logic      fifo_last_read
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // event driver
    // ****************************************
    initial begin
        {acc_sample, aux_sample, fifo_full} = 3'h0;
        {irq_one, irq_two, fifo_last_read} = 3'h0;
    end

    // ev = {acc, aux, full, irq one, irq two, last read}
    task automatic send(input logic [5:0] ev);
        @(posedge link_clk);
        acc_sample     <= ev[5];
        aux_sample     <= ev[4];
        fifo_full      <= ev[3];
        irq_one        <= ev[2];
        irq_two        <= ev[1];
        fifo_last_read <= ev[0];
        @(posedge link_clk);
        // pulses last one cycle; levels stay where the far side left them
        {acc_sample, aux_sample, fifo_last_read} <= 3'h0;
    endtask : send
endmodule : link_side_model

// ===== fifo_frame_and_aux_if_config_bench.sv
// self-checking bench of the fifo frame and secondary link setup block
module fifo_frame_and_aux_if_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_cfg_pkg::*;

    // ****************************************
    // signals and tables
    // ****************************************
    localparam logic [7:0] OFS[6] = '{8'h48,8'h49,8'h4B,8'h4C,8'h4D,8'h4E};
    localparam logic [7:0] MSK[6] = '{8'h03,8'h7C,8'hFE,8'h83,8'hFF,8'hFF};
    localparam logic [3:0] NB[4]  = '{4'h1,4'h2,4'h6,4'h8};
    logic       ref_clk, link_clk, srst, reg_we, reg_re;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fetch_ptr, store_ptr;
    logic       reg_rvalid, cfg_busy, fifo_write, time_frame, manual_mode;
    logic       acc_s, aux_s, full, irq1, irq2, last_rd;
    frame_t     frame;
    logic [6:0] slave_addr;
    logic [3:0] burst_bytes;
    logic [7:0] rq[$];
    logic [6:0] lq[$];
    int         bad_count;
    int         check_count;

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    fifo_frame_and_aux_if_config u_dut (
        .REF_CLK(ref_clk), .SRST(srst), .REG_WE(reg_we), .REG_RE(reg_re),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .CFG_BUSY(cfg_busy), .LINK_CLK(link_clk),
        .ACC_SAMPLE(acc_s), .AUX_SAMPLE(aux_s), .FIFO_FULL(full),
        .IRQ_ONE(irq1), .IRQ_TWO(irq2), .FIFO_LAST_READ(last_rd),
        .FIFO_WRITE(fifo_write), .FRAME(frame), .TIME_FRAME(time_frame),
        .SLAVE_ADDR(slave_addr), .MANUAL_MODE(manual_mode),
        .BURST_BYTES(burst_bytes), .FETCH_PTR(fetch_ptr),
        .STORE_PTR(store_ptr)
    );

    link_side_model u_link (
        .link_clk(link_clk), .acc_sample(acc_s), .aux_sample(aux_s),
        .fifo_full(full), .irq_one(irq1), .irq_two(irq2),
        .fifo_last_read(last_rd)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic do_reset;
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        // link side leaves reset two of its edges later
        repeat (8) @(posedge ref_clk);
    endtask : do_reset

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        rq.push_back(exp);
        @(posedge ref_clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_re <= 1'b0;
    endtask : reg_rd

    task automatic wait_idle;
        int n;
        n = 0;
        // poll off the launching edge so the flag is settled
        repeat (2) @(negedge ref_clk);
        while (cfg_busy !== 1'b0) begin
            @(negedge ref_clk);
            n++;
            if (n > 200) begin
                bad_count++;
                wrap_up();
            end
        end
    endtask : wait_idle

    task automatic cfg_chk(input logic [6:0] sa, input logic man,
                           input logic [3:0] nb, input logic [7:0] fp,
                           input logic [7:0] sp);
        wait_idle();
        check(slave_addr, sa);
        check(manual_mode, man);
        check(burst_bytes, nb);
        check(fetch_ptr, fp);
        check(store_ptr, sp);
    endtask : cfg_chk

    task automatic reset_chk;
        reg_rd(8'h48, 8'h02);
        reg_rd(8'h49, 8'h10);
        reg_rd(8'h4B, 8'h20);
        reg_rd(8'h4C, 8'h83);
        reg_rd(8'h4D, 8'h42);
        reg_rd(8'h4E, 8'h4C);
        reg_rd(8'h4A, 8'h00);
        cfg_chk(7'h10, 1'b1, 4'h8, 8'h42, 8'h4C);
    endtask : reset_chk

    // ****************************************
    // result watchers
    // ****************************************
    always @(negedge ref_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (rq.size() == 0) begin
                check(16'hFFFF, reg_rdata);
            end else begin
                check(reg_rdata, rq.pop_front());
            end
        end
    end

    always @(negedge link_clk) begin
        if (fifo_write === 1'b1 || time_frame === 1'b1) begin
            if (lq.size() == 0) begin
                check({time_frame, fifo_write, frame}, 16'h0);
            end else begin
                check({time_frame, fifo_write, 5'(frame) & {5{fifo_write}}},
                      lq.pop_front());
            end
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [7:0] src, opt, v1, v2, v3;
        logic [5:0] ev;
        logic       a, x;
        {srst, reg_we, reg_re, reg_addr, reg_wdata} = '0;
        bad_count   = 0;
        check_count = 0;
        void'($urandom(12));
        do_reset();
        reset_chk();
        // all ones everywhere, unmapped offset too: reserved bits stay zero
        for (int i = 0; i < 6; i++) reg_wr(OFS[i], 8'hFF);
        reg_wr(8'h4A, 8'hFF);
        for (int i = 0; i < 6; i++) reg_rd(OFS[i], MSK[i]);
        reg_rd(8'h4A, 8'h00);
        cfg_chk(7'h7F, 1'b1, 4'h8, 8'hFF, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            reg_wr(8'h4C, {i[0], 5'h1F, i[1:0]});
            reg_rd(8'h4C, {i[0], 5'h00, i[1:0]});
            cfg_chk(7'h7F, i[0], NB[i], 8'hFF, 8'hFF);
        end
        for (int i = 0; i < 4; i++) begin
            v1 = 8'($urandom);
            v2 = 8'($urandom);
            v3 = 8'($urandom);
            reg_wr(8'h4B, v1);
            reg_wr(8'h4D, v2);
            reg_wr(8'h4E, v3);
            reg_rd(8'h4B, v1 & 8'hFE);
            reg_rd(8'h4D, v2);
            reg_rd(8'h4E, v3);
            cfg_chk(v1[7:1], 1'b1, 4'h8, v2, v3);
        end
        for (int n = 0; n < 24; n++) begin
            src = 8'($urandom);
            opt = 8'($urandom);
            reg_wr(8'h49, src);
            reg_wr(8'h48, opt);
            @(negedge ref_clk);
            check(cfg_busy, 1'b1);
            wait_idle();
            for (int k = 0; k < 4; k++) begin
                ev = 6'($urandom) & 6'h3E;
                a  = ev[5] & src[6];
                x  = ev[4] & src[5];
                if ((a | x) & ~(opt[0] & ev[3])) begin
                    lq.push_back({2'h1, a, x, src[4], ev[2] & src[3],
                                  ev[1] & src[2]});
                end
                u_link.send(ev);
            end
            if (opt[1]) lq.push_back(7'h40);
            u_link.send(6'h01);
        end
        // second reset at the end of the run brings every setting back
        do_reset();
        reset_chk();
        repeat (20) @(posedge ref_clk);
        check(16'(rq.size() + lq.size()), 16'h0);
        wrap_up();
    end
endmodule : fifo_frame_and_aux_if_config_bench
